// >>> logic/msm_consts.svh
// Offsets, field positions, reset values and sizes of the misfire speed modulator.
`ifndef MSM_CONSTS_SVH
`define MSM_CONSTS_SVH

`define NUM_CYL          12
`define CYCLE_DEG        720
`define PROF_POINTS      90
`define PROF_STEP_SHIFT  3
`define PROF_ENTRIES     360
`define LIKELY_FULL      10000
`define UNITY_Q14        16'h4000
`define ATT_FULL_Q15     16'h8000
`define ADDR_W           12

`define CTRL_ADDR        12'h000
`define REF_PHASE_ADDR   12'h004
`define STATUS_ADDR      12'h008
`define SPEED_ADDR       12'h00C
`define SEQ_COMMON_ADDR  12'h010
`define CYL_CFG_BASE     12'h100
`define CYL_LIKE_BASE    12'h140
`define SEQ_IND_BASE     12'h180
`define CYL_REGION_MASK  12'hFC0
`define PROF_BASE        12'h800

`define CTRL_SINGLE_BIT  0
`define CTRL_TRIG_BIT    1
`define CTRL_SERVED_LSB  8
`define CTRL_SEQLEN_LSB  16
`define CTRL_RESET       32'h001F0C00

`define CFG_START_LSB    0
`define CFG_PROF_LSB     10
`define CFG_MODE_BIT     12
`define CFG_TYPE_BIT     13
`define CFG_ENABLE_BIT   14
`define CFG_ATT_LSB      16
`define CFG_RESET        32'h80000000

`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// >>> logic/msm_pkg.sv
// Types shared by the misfire speed modulator files.
`default_nettype none
package msm_pkg;
  typedef logic [9:0]  angle_t;
  typedef logic [15:0] q14_t;
  typedef logic [3:0]  cyl_idx_t;
  typedef enum logic [1:0] {
    SWEEP_IDLE  = 2'b00,
    SWEEP_FETCH = 2'b01,
    SWEEP_SCALE = 2'b11,
    SWEEP_ACC   = 2'b10
  } sweep_state_e;
endpackage
`default_nettype wire

// >>> logic/misfire_draw.sv
// Free-running pseudo-random draw compared against a misfire likelihood.
`timescale 1ns/100ps
`default_nettype none
`include "msm_consts.svh"
module misfire_draw (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [15:0] likelihood,
  output logic             hit
);
  logic [15:0] lfsr;
  logic [31:0] scaled;

  // The generator steps every cycle, so cylinders visited in turn see fresh values.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lfsr <= 16'hACE1;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  always_comb begin
    scaled = 32'(lfsr) * 32'(`LIKELY_FULL);
    hit    = (16'(scaled >> 16) < likelihood); // see RULE8 see RULE17
  end
endmodule // misfire_draw
`default_nettype wire

// >>> logic/profile_store.sv
// Storage for the four modulation profiles, one registered read port.
`timescale 1ns/100ps
`default_nettype none
`include "msm_consts.svh"
module profile_store (
  input  wire logic        aclk,
  input  wire logic        wr_en,
  input  wire logic [8:0]  wr_index,
  input  wire logic [15:0] wr_value,
  input  wire logic [8:0]  rd_index,
  output logic [15:0]      rd_value
);
  // Contents have no reset; software loads every profile before enabling cylinders.
  logic [15:0] points [`PROF_ENTRIES];

  always_ff @(posedge aclk) begin
    if (wr_en) begin
      points[wr_index] <= wr_value; // see RULE6
    end
  end

  always_ff @(posedge aclk) begin
    rd_value <= points[rd_index];
  end
endmodule // profile_store
`default_nettype wire

// >>> logic/misfire_speed_modulator.sv
// Per-cylinder misfire speed modulation with AXI4-Lite register access.
//
// How it works
// RULE1: Profile starts at start angle plus phase.
// RULE2: Attenuation scales modulation depth, zero means none.
// RULE3: Each cylinder selects one of four profiles.
// RULE4: Mode chooses probability or sequence playback.
// RULE5: Type chooses common or individual sequence.
// RULE6: All settings change live without restart.
// RULE7: Per-cylinder enable gates speed modulation output.
// RULE8: Likelihood 0..10000 maps to probability 0..1.
// RULE9: Likelihood ignored outside probability mode.
// RULE10: Trigger rising edge starts sequence playback.
// RULE11: Retrigger during playback restarts from beginning.
// RULE12: Only the served cylinder count is processed; misfire_active is still decided for all 12 cylinders.
// RULE13: Global reference phase shifts all cylinders.
// RULE14: Profile spans 720 degrees, unity leaves speed.
// RULE15: Overlapping cylinder factors multiply together.
// RULE16: Playback continuous or single shot.
// RULE17: One random draw per cylinder per cycle.
`timescale 1ns/100ps
`default_nettype none
`include "msm_consts.svh"
module misfire_speed_modulator (
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire msm_pkg::angle_t crank_angle,
  output msm_pkg::q14_t        speed_factor,
  output logic [11:0]          misfire_active,
  input  wire logic [11:0]     s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [11:0]     s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready
);
  import msm_pkg::*;

  logic [31:0]  ctrl;
  angle_t       ref_phase;
  logic [31:0]  seq_common;
  logic [31:0]  cyl_cfg [`NUM_CYL];
  logic [15:0]  cyl_like [`NUM_CYL];
  logic [31:0]  seq_ind [`NUM_CYL];

  logic         aw_full;
  logic [11:0]  aw_addr;
  logic         w_full;
  logic [31:0]  w_data;
  logic [3:0]   w_strb;
  logic         do_wr;
  logic         wr_cyl_cfg;
  logic         wr_cyl_like;
  logic         wr_seq_ind;
  logic         wr_prof;
  logic         wr_known;
  cyl_idx_t     wr_cyl;
  logic [11:0]  prof_off;
  logic [31:0]  rd_word;
  logic         rd_known;
  cyl_idx_t     rd_cyl;

  logic         trig_prev;
  logic         trig_rise;
  angle_t       angle_prev;
  logic         cycle_wrap;
  logic         playing;
  logic [4:0]   seq_step;
  logic         decide_pending;
  logic         decide_now;

  sweep_state_e state;
  cyl_idx_t     cyl;
  logic [31:0]  cfg_cur;
  logic [11:0]  rel_raw;
  logic [11:0]  rel_angle;
  logic [8:0]   prof_index;
  logic [15:0]  prof_value;
  logic         draw_hit;
  logic         seq_bit;
  logic         active_cur;
  logic [15:0]  att_cur;
  logic signed [16:0] depth;
  logic signed [33:0] depth_scaled;
  q14_t         cyl_factor;
  q14_t         acc;
  logic [31:0]  acc_prod;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Write address and data are taken independently and paired before the write is done.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full       <= 1'b0;
      aw_addr       <= 12'h000;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (do_wr || !aw_full) begin
      aw_full       <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full       <= 1'b0;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (do_wr || !w_full) begin
      w_full       <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  assign do_wr = aw_full && w_full && !s_axi_bvalid;

  always_comb begin
    wr_cyl      = cyl_idx_t'(aw_addr[5:2]);
    prof_off    = (aw_addr - `PROF_BASE) >> 2;
    wr_cyl_cfg  = ((aw_addr & `CYL_REGION_MASK) == `CYL_CFG_BASE) && (wr_cyl < `NUM_CYL);
    wr_cyl_like = ((aw_addr & `CYL_REGION_MASK) == `CYL_LIKE_BASE) && (wr_cyl < `NUM_CYL);
    wr_seq_ind  = ((aw_addr & `CYL_REGION_MASK) == `SEQ_IND_BASE) && (wr_cyl < `NUM_CYL);
    wr_prof     = (aw_addr >= `PROF_BASE) && (prof_off < 12'(`PROF_ENTRIES));
    wr_known    = wr_cyl_cfg || wr_cyl_like || wr_seq_ind || wr_prof ||
                  (aw_addr == `CTRL_ADDR) || (aw_addr == `REF_PHASE_ADDR) ||
                  (aw_addr == `SEQ_COMMON_ADDR);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Global settings are read live by the sweep and apply from the next cylinder visited, so no stop is ever needed.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl       <= `CTRL_RESET;
      ref_phase  <= 10'h000;
      seq_common <= 32'h00000000;
    end else if (do_wr) begin
      if (aw_addr == `CTRL_ADDR) begin
        ctrl <= merge(ctrl, w_data, w_strb); // see RULE6 see RULE16
      end
      if (aw_addr == `REF_PHASE_ADDR) begin
        ref_phase <= angle_t'(merge(32'(ref_phase), w_data, w_strb)); // see RULE13
      end
      if (aw_addr == `SEQ_COMMON_ADDR) begin
        seq_common <= merge(seq_common, w_data, w_strb);
      end
    end
  end

  for (genvar n = 0; n < `NUM_CYL; n++) begin : g_cyl_regs
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cyl_cfg[n]  <= `CFG_RESET;
        cyl_like[n] <= 16'h0000;
        seq_ind[n]  <= 32'h00000000;
      end else if (do_wr && (wr_cyl == cyl_idx_t'(n))) begin
        if (wr_cyl_cfg) begin
          cyl_cfg[n] <= merge(cyl_cfg[n], w_data, w_strb); // see RULE6
        end
        if (wr_cyl_like) begin
          cyl_like[n] <= 16'(merge(32'(cyl_like[n]), w_data, w_strb));
        end
        if (wr_seq_ind) begin
          seq_ind[n] <= merge(seq_ind[n], w_data, w_strb);
        end
      end
    end
  end

  always_comb begin
    rd_cyl   = cyl_idx_t'(s_axi_araddr[5:2]);
    rd_word  = 32'h00000000;
    rd_known = 1'b1;
    if (s_axi_araddr == `CTRL_ADDR) begin
      rd_word = ctrl;
    end else if (s_axi_araddr == `REF_PHASE_ADDR) begin
      rd_word = 32'(ref_phase);
    end else if (s_axi_araddr == `STATUS_ADDR) begin
      rd_word = {3'b000, seq_step, 7'h00, playing, 4'h0, misfire_active};
    end else if (s_axi_araddr == `SPEED_ADDR) begin
      rd_word = 32'(speed_factor);
    end else if (s_axi_araddr == `SEQ_COMMON_ADDR) begin
      rd_word = seq_common;
    end else if (rd_cyl < `NUM_CYL &&
                 (s_axi_araddr & `CYL_REGION_MASK) == `CYL_CFG_BASE) begin
      rd_word = cyl_cfg[rd_cyl];
    end else if (rd_cyl < `NUM_CYL &&
                 (s_axi_araddr & `CYL_REGION_MASK) == `CYL_LIKE_BASE) begin
      rd_word = 32'(cyl_like[rd_cyl]);
    end else if (rd_cyl < `NUM_CYL &&
                 (s_axi_araddr & `CYL_REGION_MASK) == `SEQ_IND_BASE) begin
      rd_word = seq_ind[rd_cyl];
    end else if (s_axi_araddr < `PROF_BASE) begin
      rd_known = 1'b0;
    end
  end

  // Profile points are write-only; their window reads as zero with an OKAY answer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  assign trig_rise  = ctrl[`CTRL_TRIG_BIT] && !trig_prev;
  assign cycle_wrap = crank_angle < angle_prev;

  // Playback steps once per crank cycle; a new trigger edge always wins over the step.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_prev  <= 1'b0;
      angle_prev <= 10'h000;
      playing    <= 1'b0;
      seq_step   <= 5'h00;
    end else begin
      trig_prev  <= ctrl[`CTRL_TRIG_BIT];
      angle_prev <= crank_angle;
      if (trig_rise) begin
        playing  <= 1'b1; // see RULE10 see RULE11
        seq_step <= 5'h00;
      end else if (cycle_wrap && playing) begin
        if (seq_step >= ctrl[`CTRL_SEQLEN_LSB +: 5]) begin
          seq_step <= 5'h00;
          playing  <= !ctrl[`CTRL_SINGLE_BIT]; // see RULE16
        end else begin
          seq_step <= seq_step + 5'h01;
        end
      end
    end
  end

  always_comb begin
    cfg_cur   = cyl_cfg[cyl];
    rel_raw   = 12'(crank_angle) + 12'(2 * `CYCLE_DEG)
              - 12'(cfg_cur[`CFG_START_LSB +: 10]) - 12'(ref_phase); // see RULE1 see RULE13
    rel_angle = rel_raw;
    if (rel_raw >= 12'(2 * `CYCLE_DEG)) begin
      rel_angle = rel_raw - 12'(2 * `CYCLE_DEG);
    end else if (rel_raw >= 12'(`CYCLE_DEG)) begin
      rel_angle = rel_raw - 12'(`CYCLE_DEG);
    end
    prof_index = 9'(cfg_cur[`CFG_PROF_LSB +: 2]) * 9'(`PROF_POINTS)
               + 9'(rel_angle >> `PROF_STEP_SHIFT); // see RULE3 see RULE14
    seq_bit    = cfg_cur[`CFG_TYPE_BIT] ? seq_ind[cyl][seq_step]
                                        : seq_common[seq_step]; // see RULE5
    att_cur    = (cfg_cur[`CFG_ATT_LSB +: 16] > `ATT_FULL_Q15) ? `ATT_FULL_Q15
                                                               : cfg_cur[`CFG_ATT_LSB +: 16];
    active_cur = cfg_cur[`CFG_ENABLE_BIT] && misfire_active[cyl] &&
                 (cyl < cyl_idx_t'(ctrl[`CTRL_SERVED_LSB +: 4])); // see RULE7 see RULE12
    depth        = $signed({1'b0, prof_value}) - $signed({1'b0, `UNITY_Q14});
    depth_scaled = depth * $signed({1'b0, att_cur});
    acc_prod     = 32'(acc) * 32'(cyl_factor);
  end

  misfire_draw u_draw (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .likelihood (cyl_like[cyl]),
    .hit        (draw_hit)
  );

  profile_store u_profiles (
    .aclk     (aclk),
    .wr_en    (do_wr && wr_prof && (w_strb[1:0] == 2'b11)),
    .wr_index (9'(prof_off)),
    .wr_value (w_data[15:0]),
    .rd_index (prof_index),
    .rd_value (prof_value)
  );

  // A wrap in the same cycle as the sweep start keeps the request pending.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      decide_pending <= 1'b1;
    end else if (cycle_wrap || trig_rise) begin
      decide_pending <= 1'b1;
    end else if (state == SWEEP_IDLE) begin
      decide_pending <= 1'b0;
    end
  end

  // Cylinders are visited one at a time to share the depth and product multipliers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state          <= SWEEP_IDLE;
      cyl            <= 4'h0;
      acc            <= `UNITY_Q14;
      cyl_factor     <= `UNITY_Q14;
      decide_now     <= 1'b0;
      speed_factor   <= `UNITY_Q14;
      misfire_active <= 12'h000;
    end else begin
      case (state)
        SWEEP_IDLE: begin
          cyl        <= 4'h0;
          acc        <= `UNITY_Q14;
          decide_now <= decide_pending;
          state      <= SWEEP_FETCH;
        end
        SWEEP_FETCH: begin
          if (decide_now) begin
            misfire_active[cyl] <= cfg_cur[`CFG_MODE_BIT] ? (playing && seq_bit)
                                                          : draw_hit; // see RULE4 see RULE9 see RULE17
          end
          state <= SWEEP_SCALE;
        end
        SWEEP_SCALE: begin
          if (active_cur) begin
            cyl_factor <= 16'(17'(`UNITY_Q14) + 17'(depth_scaled >>> 15)); // see RULE2
          end else begin
            cyl_factor <= `UNITY_Q14;
          end
          state <= SWEEP_ACC;
        end
        SWEEP_ACC: begin
          if (acc_prod[31:14] > 18'h0FFFF) begin
            acc <= 16'hFFFF;
          end else begin
            acc <= acc_prod[29:14]; // see RULE15
          end
          if (cyl == cyl_idx_t'(`NUM_CYL - 1)) begin
            speed_factor <= (acc_prod[31:14] > 18'h0FFFF) ? 16'hFFFF : acc_prod[29:14];
            state        <= SWEEP_IDLE;
          end else begin
            cyl   <= cyl + 4'h1;
            state <= SWEEP_FETCH;
          end
        end
        default: begin
          state <= SWEEP_IDLE;
        end
      endcase
    end
  end
endmodule // misfire_speed_modulator
`default_nettype wire

// >>> sim/msm_props.sv
// Port checker for the misfire speed modulator.
`timescale 1ns/100ps
`default_nettype none
`include "msm_consts.svh"
module msm_props (
  input wire logic            aclk,
  input wire logic            aresetn,
  input wire msm_pkg::angle_t crank_angle,
  input wire msm_pkg::q14_t   speed_factor,
  input wire logic [11:0]     misfire_active,
  input wire logic            s_axi_awvalid,
  input wire logic            s_axi_awready,
  input wire logic            s_axi_wvalid,
  input wire logic            s_axi_wready,
  input wire logic [1:0]      s_axi_bresp,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic [11:0]     s_axi_araddr,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic [31:0]     s_axi_rdata,
  input wire logic [1:0]      s_axi_rresp,
  input wire logic            s_axi_rvalid
);
  import msm_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  angle_t     prev_angle;
  logic [7:0] since_evt;
  logic [7:0] quiet;
  always_ff @(posedge aclk) begin
    prev_angle <= crank_angle;
  end
  // A decision may only move after a crank wrap or a register write such as a trigger.
  always_ff @(posedge aclk) begin
    if (!aresetn || crank_angle < prev_angle || (s_axi_wvalid && s_axi_wready)) begin
      since_evt <= 8'h00;
    end else if (since_evt != 8'hFF) begin
      since_evt <= since_evt + 8'h01;
    end
  end
  // Three full sweeps fit in the settle time, so a stale product cannot linger.
  always_ff @(posedge aclk) begin
    if (!aresetn || misfire_active != 12'h000) begin
      quiet <= 8'h00;
    end else if (quiet != 8'hFF) begin
      quiet <= quiet + 8'h01;
    end
  end
  property p_reset_out;
    $rose(aresetn) |-> speed_factor == `UNITY_Q14 && misfire_active == 12'h000
      && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  property p_aw_drop;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
  endproperty
  property p_b_bound;
    s_axi_awvalid && s_axi_awready |-> ##[1:40] s_axi_bvalid;
  endproperty
  property p_b_drop;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_prof_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr >= `PROF_BASE
      |=> s_axi_rdata == 32'h00000000 && s_axi_rresp == `RESP_OKAY;
  endproperty
  property p_cadence;
    $changed(speed_factor) |=> $stable(speed_factor) [*8];
  endproperty
  property p_unity;
    quiet >= 8'd120 |-> speed_factor == `UNITY_Q14;
  endproperty
  property p_decide;
    $changed(misfire_active) |-> since_evt <= 8'd120;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not at rest after reset");
  a_aw_drop: assert property (p_aw_drop) else $error("awready stayed high");
  a_b_bound: assert property (p_b_bound) else $error("write response missing");
  a_b_drop: assert property (p_b_drop) else $error("bvalid held after bready");
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  a_prof_read: assert property (p_prof_read) else $error("profile read not zero");
  a_cadence: assert property (p_cadence) else $error("speed factor changed mid sweep");
  a_unity: assert property (p_unity) else $error("speed factor not unity");
  a_decide: assert property (p_decide) else $error("decision without cause");
  c_two_cyl: cover property (speed_factor == 16'h1000);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
  c_misfire: cover property ($rose(misfire_active[0]));
endmodule // msm_props
bind misfire_speed_modulator msm_props u_props (.aclk, .aresetn, .crank_angle, .speed_factor,
  .misfire_active, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid);
`default_nettype wire

// >>> sim/crank_model.sv
// Behavioural speed generator stepping the crank angle.
`timescale 1ns/100ps
`default_nettype none
`include "msm_consts.svh"
module crank_model #(
  parameter int STEP = 24,
  parameter int HOLD = 128
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  output msm_pkg::angle_t crank_angle
);
  import msm_pkg::*;
  int hold_cnt;
  // Coarse steps held long keep each sweep faithful while the run stays short.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crank_angle <= '0;
      hold_cnt <= 0;
    end else if (run && hold_cnt == HOLD - 1) begin
      hold_cnt <= 0;
      crank_angle <= (int'(crank_angle) + STEP >= `CYCLE_DEG) ? '0 : crank_angle + angle_t'(STEP);
    end else if (run) begin
      hold_cnt <= hold_cnt + 1;
    end
  end
endmodule // crank_model
`default_nettype wire

// >>> sim/misfire_speed_modulator_bench.sv
// Self-checking bench for the misfire speed modulator.
`timescale 1ns/100ps
`default_nettype none
`include "msm_consts.svh"
module misfire_speed_modulator_bench;
  import msm_pkg::*;
  logic aclk, aresetn, run, rv;
  angle_t crank_angle;
  q14_t speed_factor;
  logic [11:0] misfire_active, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int err_count, check_count, cyc;
  misfire_speed_modulator DUT (.aclk, .aresetn, .crank_angle, .speed_factor, .misfire_active,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  crank_model #(.STEP(24), .HOLD(128)) u_crank (.aclk, .aresetn, .run, .crank_angle);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic complete_run();
    if (err_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 200);
    s_axi_bready <= 1'b0;
    chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, er}, "write response");
  endtask
  task automatic rd(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 200);
    s_axi_rready <= 1'b0;
    rv = s_axi_rvalid;
    rdat = s_axi_rdata;
    chk({31'h0, rv}, 32'h1, "read answer");
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    rd(a);
    chk(rdat, d, "read data");
    chk({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
  endtask
  function automatic logic [31:0] cfg(input logic [9:0] st, input logic [1:0] pf,
                                      input logic md, input logic ty, input logic en,
                                      input logic [15:0] att);
    return {att, 1'b0, en, ty, md, pf, st};
  endfunction
  task automatic cyl_set(input int n, input logic [31:0] c, input logic [15:0] lk);
    wr(`CYL_CFG_BASE + 12'(4 * n), c, `RESP_OKAY);
    wr(`CYL_LIKE_BASE + 12'(4 * n), {16'h0000, lk}, `RESP_OKAY);
  endtask
  task automatic trig(input logic [31:0] c);
    wr(`CTRL_ADDR, c, `RESP_OKAY);
    wr(`CTRL_ADDR, c | 32'h00000002, `RESP_OKAY);
  endtask
  // Decisions fall at the wrap; the settle time covers four sweeps.
  task automatic wait_wrap();
    while (crank_angle == 10'h000) @(posedge aclk);
    while (crank_angle != 10'h000) @(posedge aclk);
    repeat (150) @(posedge aclk);
  endtask
  task automatic wait_angle(input angle_t a);
    while (crank_angle !== a) @(posedge aclk);
    repeat (120) @(posedge aclk);
  endtask
  task automatic expect_out(input logic mf, input q14_t sf);
    chk({31'h0, misfire_active[0]}, {31'h0, mf}, "misfire decision");
    chk({16'h0, speed_factor}, {16'h0, sf}, "speed factor");
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_count++;
      $display("BAD %0t run did not finish", $time);
      complete_run();
    end
  end
  initial begin
    aresetn = 1'b0;
    run = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`CTRL_ADDR, `CTRL_RESET, `RESP_OKAY);
    rchk(`CYL_CFG_BASE + 12'h02C, `CFG_RESET, `RESP_OKAY);
    rchk(`REF_PHASE_ADDR, 32'h00000000, `RESP_OKAY);
    rchk(12'h020, 32'h00000000, `RESP_SLVERR);
    rchk(`PROF_BASE, 32'h00000000, `RESP_OKAY);
    wr(`STATUS_ADDR, 32'hFFFFFFFF, `RESP_SLVERR);
    for (int p = 0; p < 3; p++) begin
      for (int i = 0; i < `PROF_POINTS; i++) begin
        wr(`PROF_BASE + 12'(4 * (p * `PROF_POINTS + i)), (p == 0) ? 32'h2000 : (p == 1) ?
           32'h6000 : (i == 0) ? 32'h2000 : 32'h4000, `RESP_OKAY);
      end
    end
    run <= 1'b1;
    cyl_set(0, cfg(10'h000, 2'h0, 1'b0, 1'b0, 1'b1, 16'h8000), 16'd10000);
    wait_wrap();
    expect_out(1'b1, 16'h2000);
    cyl_set(1, cfg(10'h000, 2'h0, 1'b0, 1'b0, 1'b1, 16'h8000), 16'd10000);
    wait_wrap();
    expect_out(1'b1, 16'h1000);
    cyl_set(1, cfg(10'h000, 2'h0, 1'b0, 1'b0, 1'b0, 16'h8000), 16'd10000);
    cyl_set(0, cfg(10'h000, 2'h0, 1'b0, 1'b0, 1'b1, 16'h4000), 16'd10000);
    wait_wrap();
    expect_out(1'b1, 16'h3000);
    cyl_set(0, cfg(10'h000, 2'h0, 1'b0, 1'b0, 1'b1, 16'h0000), 16'd10000);
    wait_wrap();
    expect_out(1'b1, 16'h4000);
    cyl_set(0, cfg(10'h000, 2'h1, 1'b0, 1'b0, 1'b1, 16'h8000), 16'd10000);
    wait_wrap();
    expect_out(1'b1, 16'h6000);
    wr(`CTRL_ADDR, 32'h001F0000, `RESP_OKAY);
    wait_wrap();
    chk({16'h0, speed_factor}, 32'h00004000, "served count");
    wr(`CTRL_ADDR, `CTRL_RESET, `RESP_OKAY);
    cyl_set(0, cfg(10'h000, 2'h0, 1'b0, 1'b0, 1'b1, 16'h8000), 16'd0);
    wait_wrap();
    expect_out(1'b0, 16'h4000);
    cyl_set(0, cfg(10'h000, 2'h0, 1'b1, 1'b0, 1'b1, 16'h8000), 16'd10000);
    trig(`CTRL_RESET);
    wait_wrap();
    expect_out(1'b0, 16'h4000);
    wr(`SEQ_COMMON_ADDR, 32'hFFFFFFFF, `RESP_OKAY);
    trig(`CTRL_RESET);
    wait_wrap();
    expect_out(1'b1, 16'h2000);
    cyl_set(0, cfg(10'h000, 2'h0, 1'b1, 1'b1, 1'b1, 16'h8000), 16'd10000);
    wait_wrap();
    expect_out(1'b0, 16'h4000);
    cyl_set(0, cfg(10'h000, 2'h0, 1'b1, 1'b0, 1'b1, 16'h8000), 16'd10000);
    wait_wrap();
    rd(`STATUS_ADDR);
    chk({31'h0, rdat[16]}, 32'h1, "still playing");
    chk({31'h0, rdat[28:24] == 5'h00}, 32'h0, "step advanced");
    trig(`CTRL_RESET);
    rd(`STATUS_ADDR);
    chk({27'h0, rdat[28:24]}, 32'h0, "restart step");
    trig(32'h00000C01);
    wait_wrap();
    wait_wrap();
    rd(`STATUS_ADDR);
    chk({31'h0, rdat[16]}, 32'h0, "single shot over");
    expect_out(1'b0, 16'h4000);
    wr(`CTRL_ADDR, `CTRL_RESET, `RESP_OKAY);
    wr(`REF_PHASE_ADDR, 32'd96, `RESP_OKAY);
    cyl_set(0, cfg(10'd96, 2'h2, 1'b0, 1'b0, 1'b1, 16'h8000), 16'd10000);
    wait_wrap();
    wait_angle(10'd192);
    expect_out(1'b1, 16'h2000);
    wait_angle(10'd216);
    expect_out(1'b1, 16'h4000);
    complete_run();
  end
endmodule // misfire_speed_modulator_bench
`default_nettype wire
